//--- logic/pmc_defines.vh
// Operation
// - Eleven power modes, selectable by software
// - Reset enters normal run, regulator full
// - Wait instruction triggers wait or stop
// - Each run mode has wait and stop
// - Pin levels held in every stop-class mode
// - Normal wait: clocks on, interrupt wakes
// - Normal stop: clocks off, async wake
// - Normal stop keeps registers and voltage detect
// - Low-power run: reduced regulator, detect off
// - Low-power wait: core clock on, irq wakes
// - Low-power stop: static, adc, pin irqs
// - Low-power stop: core clock off, sram kept
// - Leakage stops allow only wake-capable units
// - Leakage stop: retention, all sram kept
// - Leakage stop exits by wake interrupt
// - Deep stops exit through wake-up reset
// - Deep stop 3 keeps both sram blocks
// - Deep stop 2 keeps part upper sram
// - Deep stop 1 keeps only register files
// - Backup only: power-up sequence to recover
// - Wake reset sets wake unit irq pending
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
`define PMC_M_RUN      4'h0
`define PMC_M_WAIT     4'h1
`define PMC_M_STOP     4'h2
`define PMC_M_LPRUN    4'h3
`define PMC_M_LPWAIT   4'h4
`define PMC_M_LPSTOP   4'h5
`define PMC_M_LLS      4'h6
`define PMC_M_DLS3     4'h7
`define PMC_M_DLS2     4'h8
`define PMC_M_DLS1     4'h9
`define PMC_M_BAT      4'ha
`define PMC_SEL_NORMAL 3'h0
`define PMC_SEL_LLS    3'h1
`define PMC_SEL_DLS3   3'h2
`define PMC_SEL_DLS2   3'h3
`define PMC_SEL_DLS1   3'h4
`define PMC_SEL_BAT    3'h5
`define PMC_WS_NONE    2'h0
`define PMC_WS_IRQ     2'h1
`define PMC_WS_WAKEIRQ 2'h2
`define PMC_WS_WAKERST 2'h3
`define PMC_CFG_RUN    8'hff
`endif

//--- logic/pmc_sync.v
`timescale 1ns/1ns
module pmc_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_r;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule

//--- logic/pmc_cfg.v
`timescale 1ns/1ns
`include "pmc_defines.vh"
// Per-mode clock, regulator, detect and retention controls
module pmc_cfg (
  input  wire [3:0] mode,
  output reg  [7:0] cfg
);
  // cfg: {sram_l, sram_u_full, sram_u_part, regfile, lvd, reg_full, nested_irq_controller, clocks}
  always @* begin
    case (mode)
      `PMC_M_RUN:    cfg = `PMC_CFG_RUN;
      `PMC_M_WAIT:   cfg = 8'hff;
      `PMC_M_STOP:   cfg = 8'hfc;
      `PMC_M_LPRUN:  cfg = 8'hf3;
      `PMC_M_LPWAIT: cfg = 8'hf3;
      `PMC_M_LPSTOP: cfg = 8'hf0;
      `PMC_M_LLS:    cfg = 8'hf0;
      `PMC_M_DLS3:   cfg = 8'hf0;
      `PMC_M_DLS2:   cfg = 8'h30;
      `PMC_M_DLS1:   cfg = 8'h10;
      `PMC_M_BAT:    cfg = 8'h00;
      default:       cfg = `PMC_CFG_RUN;
    endcase
  end
endmodule

//--- logic/pmc_top.v
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_top (
  input  wire       mclk,
  input  wire       rst,
  input  wire       wfi_exec,
  input  wire       sleep_deep,
  input  wire [2:0] stop_sel,
  input  wire       lp_run_req,
  input  wire       irq_any,
  input  wire       async_wake_irq_controller_wake,
  input  wire       leakage_wake_unit_wake,
  input  wire       bat_only_req,
  input  wire       por_done,
  output reg  [3:0] mode_r,
  output reg        periph_clk_en_r,
  output reg        nested_irq_controller_en_r,
  output reg        core_clk_en_r,
  output reg        reg_full_power_r,
  output reg        lvd_en_r,
  output reg        lp_osc_sel_r,
  output reg        flash_slow_r,
  output reg        sram_l_pwr_r,
  output reg        sram_u_pwr_r,
  output reg        sram_u_part_pwr_r,
  output reg        regfile_pwr_r,
  output reg        io_hold_r,
  output reg        wake_rst_r,
  output reg        leakage_wake_unit_pend_r,
  output reg  [3:0] last_lp_mode_r,
  output reg  [1:0] wake_src_r
);
  wire [3:0] raw_in;
  wire [3:0] sy;
  wire       async_wake_irq_controller_s;
  wire       leakage_wake_unit_s;
  wire       bat_s;
  wire       por_s;
  wire [7:0] cfg;
  reg  [3:0] mode_nxt;
  reg        rst_pulse_nxt;
  reg  [1:0] src_nxt;
  reg        lp_mode;

  assign raw_in = {async_wake_irq_controller_wake, leakage_wake_unit_wake, bat_only_req, por_done};
  assign async_wake_irq_controller_s = sy[3];
  assign leakage_wake_unit_s = sy[2];
  assign bat_s  = sy[1];
  assign por_s  = sy[0];

  // Wake sources arrive from always-on logic outside this clock
  pmc_sync #(.W(4)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (raw_in),
    .q    (sy)
  );

  pmc_cfg u_cfg (
    .mode (mode_r),
    .cfg  (cfg)
  );

  always @* begin
    mode_nxt      = mode_r;
    rst_pulse_nxt = 1'b0;
    src_nxt       = wake_src_r;
    lp_mode       = (mode_r == `PMC_M_LPRUN);
    case (mode_r)
      `PMC_M_RUN, `PMC_M_LPRUN: begin
        if (bat_s) begin
          mode_nxt = `PMC_M_BAT;
        end else if (wfi_exec) begin
          if (!sleep_deep) begin
            mode_nxt = lp_mode ? `PMC_M_LPWAIT : `PMC_M_WAIT;
          end else if (lp_mode) begin
            mode_nxt = `PMC_M_LPSTOP;
          end else begin
            case (stop_sel)
              `PMC_SEL_NORMAL: mode_nxt = `PMC_M_STOP;
              `PMC_SEL_LLS:    mode_nxt = `PMC_M_LLS;
              `PMC_SEL_DLS3:   mode_nxt = `PMC_M_DLS3;
              `PMC_SEL_DLS2:   mode_nxt = `PMC_M_DLS2;
              `PMC_SEL_DLS1:   mode_nxt = `PMC_M_DLS1;
              `PMC_SEL_BAT:    mode_nxt = `PMC_M_BAT;
              default:         mode_nxt = `PMC_M_STOP;
            endcase
          end
        end else if (mode_r == `PMC_M_RUN && lp_run_req) begin
          mode_nxt = `PMC_M_LPRUN;
        end else if (mode_r == `PMC_M_LPRUN && !lp_run_req) begin
          mode_nxt = `PMC_M_RUN;
        end
      end
      `PMC_M_WAIT: begin
        if (irq_any) begin
          mode_nxt = `PMC_M_RUN;
          src_nxt  = `PMC_WS_IRQ;
        end
      end
      `PMC_M_LPWAIT: begin
        if (irq_any) begin
          mode_nxt = `PMC_M_LPRUN;
          src_nxt  = `PMC_WS_IRQ;
        end
      end
      `PMC_M_STOP, `PMC_M_LPSTOP: begin
        if (async_wake_irq_controller_s) begin
          mode_nxt = (mode_r == `PMC_M_STOP) ? `PMC_M_RUN : `PMC_M_LPRUN;
          src_nxt  = `PMC_WS_IRQ;
        end
      end
      `PMC_M_LLS: begin
        if (leakage_wake_unit_s) begin
          mode_nxt = `PMC_M_RUN;
          src_nxt  = `PMC_WS_WAKEIRQ;
        end
      end
      `PMC_M_DLS3, `PMC_M_DLS2, `PMC_M_DLS1: begin
        if (leakage_wake_unit_s) begin
          mode_nxt      = `PMC_M_RUN;
          rst_pulse_nxt = 1'b1;
          src_nxt       = `PMC_WS_WAKERST;
        end
      end
      `PMC_M_BAT: begin
        if (por_s) begin
          mode_nxt = `PMC_M_RUN;
          src_nxt  = `PMC_WS_NONE;
        end
      end
      default: mode_nxt = `PMC_M_RUN;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r            <= `PMC_M_RUN;
      periph_clk_en_r   <= 1'b1;
      nested_irq_controller_en_r         <= 1'b1;
      core_clk_en_r     <= 1'b1;
      reg_full_power_r  <= 1'b1;
      lvd_en_r          <= 1'b1;
      lp_osc_sel_r      <= 1'b0;
      flash_slow_r      <= 1'b0;
      sram_l_pwr_r      <= 1'b1;
      sram_u_pwr_r      <= 1'b1;
      sram_u_part_pwr_r <= 1'b1;
      regfile_pwr_r     <= 1'b1;
      io_hold_r         <= 1'b0;
      wake_rst_r        <= 1'b0;
      leakage_wake_unit_pend_r       <= 1'b0;
      last_lp_mode_r    <= `PMC_M_RUN;
      wake_src_r        <= `PMC_WS_NONE;
    end else begin
      mode_r            <= mode_nxt;
      periph_clk_en_r   <= cfg[0];
      nested_irq_controller_en_r         <= cfg[1];
      core_clk_en_r     <= cfg[1];
      reg_full_power_r  <= cfg[2];
      lvd_en_r          <= cfg[3];
      lp_osc_sel_r      <= (mode_r == `PMC_M_LPRUN) || (mode_r == `PMC_M_LPWAIT);
      flash_slow_r      <= (mode_r == `PMC_M_LPRUN) || (mode_r == `PMC_M_LPWAIT);
      regfile_pwr_r     <= cfg[4];
      sram_u_part_pwr_r <= cfg[5];
      sram_u_pwr_r      <= cfg[6];
      sram_l_pwr_r      <= cfg[7];
      // Pads latch while any stop-class mode is active
      io_hold_r         <= (mode_r != `PMC_M_RUN) && (mode_r != `PMC_M_LPRUN) &&
                           (mode_r != `PMC_M_WAIT) && (mode_r != `PMC_M_LPWAIT);
      wake_rst_r        <= rst_pulse_nxt;
      if (rst_pulse_nxt) begin
        leakage_wake_unit_pend_r <= 1'b1;
      end else if (mode_r == `PMC_M_RUN && irq_any) begin
        leakage_wake_unit_pend_r <= 1'b0;
      end
      if (mode_nxt != mode_r && mode_r != `PMC_M_RUN && mode_r != `PMC_M_LPRUN) begin
        last_lp_mode_r <= mode_r;
      end
      wake_src_r        <= src_nxt;
    end
  end
endmodule

//--- testbench/pmc_wake_model.sv
`timescale 1ns/1ns
module pmc_wake_model (
  input  wire       mclk,
  input  wire       rst,
  input  wire       wake_req,
  input  wire [3:0] mode,
  output reg        async_wake_irq_controller_wake,
  output reg        leakage_wake_unit_wake
);
  // Wake lines drop on their own once the mode leaves stop
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      async_wake_irq_controller_wake <= 1'b0;
      leakage_wake_unit_wake <= 1'b0;
    end else begin
      async_wake_irq_controller_wake <= wake_req && (mode == 4'h2 || mode == 4'h5);
      leakage_wake_unit_wake <= wake_req && mode >= 4'h6 && mode <= 4'h9;
    end
  end
endmodule

//--- testbench/pmc_top_chk.sv
`timescale 1ns/1ns
module pmc_chk (
  input wire       mclk,
  input wire       rst,
  input wire       wfi_exec,
  input wire       sleep_deep,
  input wire [2:0] stop_sel,
  input wire       irq_any,
  input wire [3:0] mode_r,
  input wire       periph_clk_en_r,
  input wire       nested_irq_controller_en_r,
  input wire       core_clk_en_r,
  input wire       reg_full_power_r,
  input wire       lvd_en_r,
  input wire       lp_osc_sel_r,
  input wire       flash_slow_r,
  input wire       sram_l_pwr_r,
  input wire       sram_u_part_pwr_r,
  input wire       io_hold_r,
  input wire       wake_rst_r,
  input wire       leakage_wake_unit_pend_r,
  input wire [1:0] wake_src_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_reset_run: assert property ($fell(rst) |-> mode_r == 4'h0 && reg_full_power_r)
    else $error("not in run after reset");
  chk_run_ctl: assert property (mode_r == 4'h0 && $past(mode_r) == 4'h0
    |-> sram_l_pwr_r && reg_full_power_r && lvd_en_r && nested_irq_controller_en_r) else $error("run ctl");
  chk_wfi_wait: assert property (mode_r == 4'h0 && wfi_exec && !sleep_deep |=> mode_r == 4'h1)
    else $error("wait not entered");
  chk_wfi_stop: assert property (mode_r == 4'h0 && wfi_exec && sleep_deep
    && stop_sel == 3'h0 |=> mode_r == 4'h2) else $error("stop not entered");
  chk_lp_stop: assert property (mode_r == 4'h3 && wfi_exec && sleep_deep |=> mode_r == 4'h5)
    else $error("low power stop not entered");
  chk_irq_return: assert property ((mode_r == 4'h1 || mode_r == 4'h4) && irq_any
    |=> mode_r == $past(mode_r) - 4'h1) else $error("irq did not return to run");
  chk_stop_ctl: assert property (mode_r == 4'h2 && $past(mode_r) == 4'h2
    |-> !periph_clk_en_r && !nested_irq_controller_en_r && lvd_en_r && io_hold_r) else $error("stop controls");
  chk_lprun_ctl: assert property (mode_r == 4'h3 && $past(mode_r) == 4'h3
    |-> !reg_full_power_r && !lvd_en_r && lp_osc_sel_r && flash_slow_r && nested_irq_controller_en_r)
    else $error("lprun ctl");
  chk_lpstop_ctl: assert property (mode_r == 4'h5 && $past(mode_r) == 4'h5
    |-> !core_clk_en_r && !nested_irq_controller_en_r && !lvd_en_r && sram_l_pwr_r) else $error("lpstop ctl");
  chk_deep_two: assert property (mode_r == 4'h8 && $past(mode_r) == 4'h8
    |-> !sram_l_pwr_r && sram_u_part_pwr_r) else $error("deep stop 2 sram");
  chk_wake_pulse: assert property (wake_rst_r |-> mode_r == 4'h0 && leakage_wake_unit_pend_r
    && wake_src_r == 2'h3 ##1 !wake_rst_r) else $error("wake reset pulse");
  cover property (mode_r == 4'h9);
  cover property (wake_rst_r);
  cover property (mode_r == 4'ha);
endmodule
bind pmc_top pmc_chk i_pmc_chk (.mclk(mclk), .rst(rst), .wfi_exec(wfi_exec),
  .sleep_deep(sleep_deep), .stop_sel(stop_sel), .irq_any(irq_any), .mode_r(mode_r),
  .periph_clk_en_r(periph_clk_en_r), .nested_irq_controller_en_r(nested_irq_controller_en_r), .core_clk_en_r(core_clk_en_r),
  .reg_full_power_r(reg_full_power_r), .lvd_en_r(lvd_en_r), .lp_osc_sel_r(lp_osc_sel_r),
  .flash_slow_r(flash_slow_r), .sram_l_pwr_r(sram_l_pwr_r), .io_hold_r(io_hold_r),
  .sram_u_part_pwr_r(sram_u_part_pwr_r), .wake_rst_r(wake_rst_r),
  .leakage_wake_unit_pend_r(leakage_wake_unit_pend_r), .wake_src_r(wake_src_r));

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg       mclk, rst, wfi_exec, sleep_deep, lp_run_req, irq_any, bat_only_req, wake_req;
  reg [2:0] stop_sel;
  reg       por_done;
  wire      async_wake_irq_controller_wake, leakage_wake_unit_wake, pc, nv, cc, rf, lv, lo, fs, sl, su, sp, rg, ih, wr, lp;
  wire [3:0] mode_r, last_r;
  wire [1:0] src_r;
  integer   err_count, compares, s, pulses;
  pmc_top i_pmc_top (.mclk(mclk), .rst(rst), .wfi_exec(wfi_exec), .sleep_deep(sleep_deep),
    .stop_sel(stop_sel), .lp_run_req(lp_run_req), .irq_any(irq_any), .async_wake_irq_controller_wake(async_wake_irq_controller_wake),
    .leakage_wake_unit_wake(leakage_wake_unit_wake), .bat_only_req(bat_only_req), .por_done(por_done), .mode_r(mode_r),
    .periph_clk_en_r(pc), .nested_irq_controller_en_r(nv), .core_clk_en_r(cc), .reg_full_power_r(rf),
    .lvd_en_r(lv), .lp_osc_sel_r(lo), .flash_slow_r(fs), .sram_l_pwr_r(sl), .sram_u_pwr_r(su),
    .sram_u_part_pwr_r(sp), .regfile_pwr_r(rg), .io_hold_r(ih), .wake_rst_r(wr),
    .leakage_wake_unit_pend_r(lp), .last_lp_mode_r(last_r), .wake_src_r(src_r));
  pmc_wake_model i_pmc_wake_model (.mclk(mclk), .rst(rst), .wake_req(wake_req), .mode(mode_r),
    .async_wake_irq_controller_wake(async_wake_irq_controller_wake), .leakage_wake_unit_wake(leakage_wake_unit_wake));
  always #25 mclk = ~mclk;
  // Counts wake-up reset pulses seen on the design's output
  always @(posedge mclk) begin
    if (wr === 1'b1) pulses <= pulses + 1;
  end
  task chk(input [3:0] seen, input [3:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task go(input [3:0] m);
    integer i;
    for (i = 0; i < 20 && mode_r !== m; i = i + 1) @(negedge mclk);
    if (mode_r !== m) begin
      err_count = err_count + 1;
      $display("BAD %0t mode timeout", $time);
      give_verdict;
    end
    repeat (2) @(negedge mclk);
  endtask
  task wait_for_irq_instruction(input d, input [2:0] sel);
    @(posedge mclk) {wfi_exec, sleep_deep, stop_sel} <= {1'b1, d, sel};
    @(posedge mclk) wfi_exec <= 1'b0;
  endtask
  task irq(input [3:0] m);
    @(posedge mclk) irq_any <= 1'b1;
    go(m);
    @(posedge mclk) irq_any <= 1'b0;
  endtask
  task wake(input [3:0] m);
    @(posedge mclk) wake_req <= 1'b1;
    go(m);
    @(posedge mclk) wake_req <= 1'b0;
  endtask
  task t_run_modes;
    repeat (2) @(negedge mclk);
    chk({sl, su, rg}, 7);
    wait_for_irq_instruction(0, 3'h0); go(4'h1); chk({pc, nv}, 3);
    irq(4'h0);
    wait_for_irq_instruction(1, 3'h0); go(4'h2); chk({pc, lv, ih}, 3);
    wake(4'h0); chk(src_r, 1);
    $display("run wait stop done");
  endtask
  task t_lp_modes;
    @(posedge mclk) lp_run_req <= 1'b1;
    go(4'h3); chk({rf, lv, lo, fs}, 3);
    chk({pc, nv}, 3);
    wait_for_irq_instruction(0, 3'h0); go(4'h4); chk({cc, nv}, 3);
    irq(4'h3);
    wait_for_irq_instruction(1, 3'h3); go(4'h5); chk({cc, sl, su}, 3);
    wake(4'h3);
    @(posedge mclk) lp_run_req <= 1'b0;
    go(4'h0);
    $display("low power done");
  endtask
  task t_leak_modes;
    for (s = 1; s < 5; s = s + 1) begin
      wait_for_irq_instruction(1, s[2:0]); go(4'h5 + s[3:0]); chk(ih, 1);
      if (s == 2) chk({sl, su}, 3);
      if (s == 3) chk({sl, su, sp}, 1);
      if (s == 4) chk({sl, su, rg}, 1);
      wake(4'h0); chk(last_r, 4'h5 + s[3:0]);
      chk(src_r, s == 1 ? 2 : 3);
      chk(pulses[3:0], s[3:0] - 4'h1);
      chk(lp, s != 1);
      irq(4'h0);
    end
    $display("leakage stops done");
  endtask
  task t_backup;
    @(posedge mclk) bat_only_req <= 1'b1;
    go(4'ha);
    @(posedge mclk) bat_only_req <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(mode_r, 4'ha); chk({sl, su, rg}, 0);
    @(posedge mclk) por_done <= 1'b1;
    go(4'h0); chk(src_r, 0); chk(last_r, 4'ha);
    @(posedge mclk) {rst, por_done} <= 2'b10;
    @(posedge mclk) rst <= 1'b0;
    go(4'h0); chk(rf, 1);
    $display("backup done");
  endtask
  initial begin
    {mclk, rst, wfi_exec, sleep_deep, lp_run_req, irq_any, bat_only_req, wake_req} = 8'h40;
    stop_sel = 3'h0;
    por_done = 1'b0;
    pulses = 0;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_run_modes;
    t_lp_modes;
    t_leak_modes;
    t_backup;
    give_verdict;
  end
endmodule
